// ==== hdl/dcr_pkg.sv ====
// constants, field layout and packing helpers for the capability register bank
package dcr_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;

  // ==========================================================
  // word addresses on the 16-bit register port
  localparam logic [11:0] ADDR_PART_ID = 12'h882;
  localparam logic [11:0] ADDR_SILICON_REV = 12'h883;
  localparam logic [11:0] ADDR_CAP1 = 12'h886;
  localparam logic [11:0] ADDR_CAP2 = 12'h888;
  localparam logic [11:0] ADDR_CAP3 = 12'h88A;

  // ==========================================================
  // field positions
  localparam int CAP1_PART_LSB = 22;
  localparam int CAP1_FLOAT_BIT = 13;
  localparam int CAP1_RAM_LSB = 3;
  localparam int CAP2_CAN_BIT = 27;
  localparam int CAP2_ENC_BIT = 16;
  localparam int CAP2_CAPT_BIT = 12;
  localparam int CAP2_I2C_BIT = 8;
  localparam int CAP2_SPI_BIT = 4;
  localparam int CAP2_SER_LSB = 0;
  localparam int CAP3_TRIP_LSB = 13;
  localparam int CAP3_PWM_LSB = 0;
  localparam int PART_ID_NUM_LSB = 0;

  // defined bits; everything else is reserved and reads zero
  localparam logic [31:0] CAP1_DEFINED = 32'h3FC0_2078;
  localparam logic [31:0] CAP2_DEFINED = 32'h0801_1117;
  localparam logic [31:0] CAP3_DEFINED = 32'h000F_E07F;

  // ==========================================================
  // values after reset
  localparam logic [15:0] RDATA_RST = 16'h0000;
  localparam logic PULSE_RST = 1'b0;

  // ==========================================================
  // helpers
  function automatic logic is_cap_addr(input logic [11:0] a);
    is_cap_addr = (a >= ADDR_CAP1) && (a <= (ADDR_CAP3 + 12'h001));
  endfunction : is_cap_addr

  function automatic logic [31:0] pack_cap1(input logic [7:0] part, input logic fa,
                                            input logic [3:0] ram);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[CAP1_PART_LSB +: 8] = part;
    v[CAP1_FLOAT_BIT] = fa;
    v[CAP1_RAM_LSB +: 4] = ram;
    pack_cap1 = v & CAP1_DEFINED;
  endfunction : pack_cap1

  function automatic logic [31:0] pack_cap2(input logic can, input logic enc,
                                            input logic capt, input logic i2c,
                                            input logic spi, input logic [2:0] ser);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[CAP2_CAN_BIT] = can;
    v[CAP2_ENC_BIT] = enc;
    v[CAP2_CAPT_BIT] = capt;
    v[CAP2_I2C_BIT] = i2c;
    v[CAP2_SPI_BIT] = spi;
    v[CAP2_SER_LSB +: 3] = ser;
    pack_cap2 = v & CAP2_DEFINED;
  endfunction : pack_cap2

  function automatic logic [31:0] pack_cap3(input logic [6:0] trip, input logic [6:0] pwm);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[CAP3_TRIP_LSB +: 7] = trip;
    v[CAP3_PWM_LSB +: 7] = pwm;
    pack_cap3 = v & CAP3_DEFINED;
  endfunction : pack_cap3

endpackage : dcr_pkg

// ==== hdl/dcr_rd_mux.sv ====
// read-side address decode and word select
`timescale 1ns/100ps
module dcr_rd_mux (
  input wire logic [11:0] addr_i,
  input wire logic [31:0] cap1_i,
  input wire logic [31:0] cap2_i,
  input wire logic [31:0] cap3_i,
  input wire logic [15:0] part_id_i,
  input wire logic [15:0] silicon_rev_i,
  output logic [15:0] data_o
);

  // ==========================================================
  // select; unmapped words answer zero
  always_comb begin
    data_o = 16'h0000;
    case (addr_i)
      dcr_pkg::ADDR_PART_ID: data_o = part_id_i;
      dcr_pkg::ADDR_SILICON_REV: data_o = silicon_rev_i;
      dcr_pkg::ADDR_CAP1: data_o = cap1_i[15:0];
      dcr_pkg::ADDR_CAP1 + 12'h001: data_o = cap1_i[31:16];
      dcr_pkg::ADDR_CAP2: data_o = cap2_i[15:0];
      dcr_pkg::ADDR_CAP2 + 12'h001: data_o = cap2_i[31:16];
      dcr_pkg::ADDR_CAP3: data_o = cap3_i[15:0];
      dcr_pkg::ADDR_CAP3 + 12'h001: data_o = cap3_i[31:16];
      default: data_o = 16'h0000;
    endcase
  end

endmodule : dcr_rd_mux

// ==== hdl/dcr_wr_guard.sv ====
// protected-write qualification for the capability words
`timescale 1ns/100ps
module dcr_wr_guard (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [11:0] addr_i,
  input wire logic prot_wr_en_i,
  output logic wr_done_o,
  output logic wr_blocked_o
);

  logic cap_wr;

  assign cap_wr = wr_i && dcr_pkg::is_cap_addr(addr_i);

  // ==========================================================
  // one-cycle outcome pulses; the stored contents never change either way
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_done_o <= dcr_pkg::PULSE_RST;
      wr_blocked_o <= dcr_pkg::PULSE_RST;
    end else begin
      wr_done_o <= cap_wr && prot_wr_en_i;
      wr_blocked_o <= cap_wr && !prot_wr_en_i;
    end
  end

endmodule : dcr_wr_guard

// ==== hdl/dcr_regs.sv ====
// identification and capability register bank, top level
`timescale 1ns/100ps

// Functional notes
// - Capability one bits 29..22 hold the part number, also read in identification bits 7..0.
// - Capability one bit 13 reads one exactly when the float control accelerator exists.
// - Capability one bits 6..3 flag local RAM blocks three down to zero.
// - Capability two bit 27 reads one only when the CAN controller is present.
// - Capability two bit 16 reads one when the quadrature encoder is present.
// - Capability two bit 8 flags the I2C controller and bit 4 the SPI controller.
// - Capability two bits 2..0 flag the third, second and first serial ports.
// - Capability three bits 19..13 flag trip filters seven down to one.
// - Capability three bits 6..0 flag PWM channels seven down to one.
// - Capability contents are fixed by the part and a zero bit means the module is absent.
// - Capability one spans 0x886 and 0x887 and takes writes only under protected access.
// - Capability two and three span two words at 0x888 and 0x88A and are protected likewise.
module dcr_regs #(
  parameter logic [7:0] PART_NUMBER = 8'h5A,
  parameter logic [7:0] PART_CLASS = 8'h03,
  parameter logic [15:0] SILICON_REV = 16'h0A5C,
  parameter logic HAS_FLOAT_ACCEL = 1'b1,
  parameter logic [3:0] RAM_BLOCKS = 4'hF,
  parameter logic HAS_CAN = 1'b1,
  parameter logic HAS_ENCODER = 1'b1,
  parameter logic HAS_CAPTURE = 1'b1,
  parameter logic HAS_I2C = 1'b1,
  parameter logic HAS_SPI = 1'b1,
  parameter logic [2:0] SERIAL_PORTS = 3'h7,
  parameter logic [6:0] TRIP_FILTERS = 7'h7F,
  parameter logic [6:0] PWM_CHANNELS = 7'h7F
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic prot_wr_en_i,
  output logic [15:0] rdata_o,
  output logic wr_done_o,
  output logic wr_blocked_o
);

  // ==========================================================
  // fixed part values (PART_CLASS, PART_NUMBER, SILICON_REV defaults are arbitrary)
  localparam logic [31:0] CAP1_VAL =
    dcr_pkg::pack_cap1(PART_NUMBER, HAS_FLOAT_ACCEL, RAM_BLOCKS);
  localparam logic [31:0] CAP2_VAL =
    dcr_pkg::pack_cap2(HAS_CAN, HAS_ENCODER, HAS_CAPTURE, HAS_I2C, HAS_SPI, SERIAL_PORTS);
  localparam logic [31:0] CAP3_VAL =
    dcr_pkg::pack_cap3(TRIP_FILTERS, PWM_CHANNELS);
  localparam logic [15:0] PART_ID_VAL = {PART_CLASS, PART_NUMBER};

  logic [31:0] cap1_q;
  logic [31:0] cap2_q;
  logic [31:0] cap3_q;
  logic [15:0] part_id_q;
  logic [15:0] rdata_d;
  logic [15:0] mux_data;

  // ==========================================================
  // capability storage, loaded under system reset and then held
  // writes are deliberately not wired in: the contents are a property of the part
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cap1_q <= CAP1_VAL;
      cap2_q <= CAP2_VAL;
      cap3_q <= CAP3_VAL;
    end else begin
      cap1_q <= cap1_q;
      cap2_q <= cap2_q;
      cap3_q <= cap3_q;
    end
  end

  // identification echoes the number field of capability one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      part_id_q <= PART_ID_VAL;
    end else begin
      part_id_q <= {part_id_q[15:8], cap1_q[dcr_pkg::CAP1_PART_LSB +: 8]};
    end
  end

  // ==========================================================
  // read path
  dcr_rd_mux u_rd_mux (
    .addr_i(addr_i),
    .cap1_i(cap1_q),
    .cap2_i(cap2_q),
    .cap3_i(cap3_q),
    .part_id_i(part_id_q),
    .silicon_rev_i(SILICON_REV),
    .data_o(mux_data)
  );

  // data stands only in the cycle after the strobe, zero otherwise
  assign rdata_d = rd_i ? mux_data : dcr_pkg::RDATA_RST;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= dcr_pkg::RDATA_RST;
    end else begin
      rdata_o <= rdata_d;
    end
  end

  // ==========================================================
  // write path
  dcr_wr_guard u_wr_guard (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_i),
    .addr_i(addr_i),
    .prot_wr_en_i(prot_wr_en_i),
    .wr_done_o(wr_done_o),
    .wr_blocked_o(wr_blocked_o)
  );

  // ==========================================================
  // assertions
  logic rd_q;
  logic [11:0] rd_addr_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_q <= 1'b0;
      rd_addr_q <= 12'h000;
    end else begin
      rd_q <= rd_i;
      rd_addr_q <= addr_i;
    end
  end

  property p_part_number;
    @(posedge clk_i) disable iff (rst_i)
    rd_q && (rd_addr_q == dcr_pkg::ADDR_CAP1 + 12'h001)
      |-> rdata_o[13:6] == PART_NUMBER;
  endproperty
  a_part_number: assert property (p_part_number)
    else $error("part number field wrong in capability one");

  property p_part_echo;
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == dcr_pkg::ADDR_PART_ID)
      |=> rdata_o[7:0] == PART_NUMBER;
  endproperty
  a_part_echo: assert property (p_part_echo)
    else $error("identification low byte differs from part number field");

  property p_float_accel;
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == dcr_pkg::ADDR_CAP1)
      |=> rdata_o[13] == HAS_FLOAT_ACCEL;
  endproperty
  a_float_accel: assert property (p_float_accel)
    else $error("float accelerator flag wrong");

  property p_ram_blocks;
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == dcr_pkg::ADDR_CAP1)
      |-> ##1 rdata_o[6:3] == RAM_BLOCKS;
  endproperty
  a_ram_blocks: assert property (p_ram_blocks)
    else $error("ram block flags wrong");

  property p_can;
    @(posedge clk_i) disable iff (rst_i)
    rd_q && (rd_addr_q == dcr_pkg::ADDR_CAP2 + 12'h001)
      |-> rdata_o[11] == HAS_CAN;
  endproperty
  a_can: assert property (p_can)
    else $error("can flag wrong");

  property p_encoder;
    @(posedge clk_i) disable iff (rst_i)
    rd_q && (rd_addr_q == dcr_pkg::ADDR_CAP2 + 12'h001)
      |-> rdata_o[0] == HAS_ENCODER;
  endproperty
  a_encoder: assert property (p_encoder)
    else $error("encoder flag wrong");

  property p_capture;
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == dcr_pkg::ADDR_CAP2)
      |=> rdata_o[12] == HAS_CAPTURE;
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture flag wrong");

  property p_i2c_spi;
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == dcr_pkg::ADDR_CAP2)
      |=> (rdata_o[8] == HAS_I2C) && (rdata_o[4] == HAS_SPI);
  endproperty
  a_i2c_spi: assert property (p_i2c_spi)
    else $error("i2c or spi flag wrong");

  property p_serial;
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == dcr_pkg::ADDR_CAP2)
      |=> rdata_o[2:0] == SERIAL_PORTS;
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial port flags wrong");

  property p_trip_low;
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == dcr_pkg::ADDR_CAP3)
      |=> rdata_o[15:13] == TRIP_FILTERS[2:0];
  endproperty
  a_trip_low: assert property (p_trip_low)
    else $error("trip filter flags one to three wrong");

  property p_trip_high;
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == dcr_pkg::ADDR_CAP3 + 12'h001)
      |=> rdata_o[3:0] == TRIP_FILTERS[6:3];
  endproperty
  a_trip_high: assert property (p_trip_high)
    else $error("trip filter flags four to seven wrong");

  property p_pwm;
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == dcr_pkg::ADDR_CAP3)
      |=> rdata_o[6:0] == PWM_CHANNELS;
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("pwm channel flags wrong");

  property p_fixed;
    @(posedge clk_i) disable iff (rst_i)
    (cap1_q == CAP1_VAL) && (cap2_q == CAP2_VAL) && (cap3_q == CAP3_VAL);
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("capability contents drifted from the part values");

  property p_blocked;
    @(posedge clk_i) disable iff (rst_i)
    wr_i && !prot_wr_en_i && dcr_pkg::is_cap_addr(addr_i)
      |=> wr_blocked_o && !wr_done_o;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("unprotected capability write not refused");

  property p_accepted;
    @(posedge clk_i) disable iff (rst_i)
    wr_i && prot_wr_en_i && dcr_pkg::is_cap_addr(addr_i)
      |=> wr_done_o && !wr_blocked_o && $stable(cap2_q) && $stable(cap3_q);
  endproperty
  a_accepted: assert property (p_accepted)
    else $error("protected capability write not accepted cleanly");

  property p_no_spurious;
    @(posedge clk_i) disable iff (rst_i)
    !(wr_i && dcr_pkg::is_cap_addr(addr_i)) |=> !wr_done_o && !wr_blocked_o;
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("write outcome pulse without a capability write");

  property p_reserved_zero;
    @(posedge clk_i) disable iff (rst_i)
    ((cap1_q & ~dcr_pkg::CAP1_DEFINED) == 32'h0000_0000)
      && ((cap2_q & ~dcr_pkg::CAP2_DEFINED) == 32'h0000_0000)
      && ((cap3_q & ~dcr_pkg::CAP3_DEFINED) == 32'h0000_0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved capability bit reads one");

  property p_reserved_read;
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == dcr_pkg::ADDR_CAP1 + 12'h001)
      |=> (rdata_o[15:14] == 2'h0) && (rdata_o[5:0] == 6'h00);
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("reserved bits of capability one high word read one");

  property p_reserved_low1;
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == dcr_pkg::ADDR_CAP1)
      |=> (rdata_o[15:14] == 2'h0) && (rdata_o[12:7] == 6'h00) && (rdata_o[2:0] == 3'h0);
  endproperty
  a_reserved_low1: assert property (p_reserved_low1)
    else $error("reserved bits of capability one low word read one");

  property p_reserved_high2;
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == dcr_pkg::ADDR_CAP2 + 12'h001)
      |=> (rdata_o[15:12] == 4'h0) && (rdata_o[10:1] == 10'h000);
  endproperty
  a_reserved_high2: assert property (p_reserved_high2)
    else $error("reserved bits of capability two high word read one");

  property p_reserved_high3;
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == dcr_pkg::ADDR_CAP3 + 12'h001)
      |=> rdata_o[15:4] == 12'h000;
  endproperty
  a_reserved_high3: assert property (p_reserved_high3)
    else $error("reserved bits of capability three high word read one");

  // write data is only looked at here: it must never reach the stored words
  property p_write_ignored;
    @(posedge clk_i) disable iff (rst_i)
    wr_i && (wdata_i != 16'h0000) && dcr_pkg::is_cap_addr(addr_i)
      |=> $stable(cap1_q) && $stable(cap2_q) && $stable(cap3_q);
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("capability write altered stored contents");

  property p_read_window;
    @(posedge clk_i) disable iff (rst_i)
    !rd_i |=> rdata_o == 16'h0000;
  endproperty
  a_read_window: assert property (p_read_window)
    else $error("read data outside the answer cycle");

  // ==========================================================
  // covers
  property p_cov_cap_read;
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == dcr_pkg::ADDR_CAP1) ##1 rd_i && (addr_i == dcr_pkg::ADDR_CAP1 + 12'h001);
  endproperty
  c_cov_cap_read: cover property (p_cov_cap_read);

  property p_cov_blocked;
    @(posedge clk_i) disable iff (rst_i)
    wr_blocked_o;
  endproperty
  c_cov_blocked: cover property (p_cov_blocked);

  property p_cov_accepted;
    @(posedge clk_i) disable iff (rst_i)
    wr_done_o;
  endproperty
  c_cov_accepted: cover property (p_cov_accepted);

  property p_cov_id_read;
    @(posedge clk_i) disable iff (rst_i)
    rd_i && (addr_i == dcr_pkg::ADDR_PART_ID) ##1 rd_i && (addr_i == dcr_pkg::ADDR_SILICON_REV);
  endproperty
  c_cov_id_read: cover property (p_cov_id_read);

endmodule : dcr_regs

// ==== dv/tb_device_capability_id_regs.sv ====
// self-checking testbench for the identification and capability register bank
`timescale 1ns/100ps
module tb_device_capability_id_regs;
  // ==========================================================
  // part configuration: a mix of present and absent modules
  localparam logic [7:0] P_PART = 8'hC3;
  localparam logic [7:0] P_CLASS = 8'h3C; // arbitrary value
  localparam logic [15:0] P_REV = 16'h1234; // arbitrary value
  localparam logic P_FA = 1'b0;
  localparam logic [3:0] P_RAM = 4'hA;
  localparam logic P_CAN = 1'b0;
  localparam logic P_ENC = 1'b1;
  localparam logic P_CAPT = 1'b0;
  localparam logic P_I2C = 1'b1;
  localparam logic P_SPI = 1'b0;
  localparam logic [2:0] P_SER = 3'h5;
  localparam logic [6:0] P_TRIP = 7'h55;
  localparam logic [6:0] P_PWM = 7'h2B;
  // expected words built bit by bit; every gap is a reserved zero
  localparam logic [31:0] EXP_CAP1 = {2'h0, P_PART, 8'h00, P_FA, 6'h00, P_RAM, 3'h0};
  localparam logic [31:0] EXP_CAP2 = {4'h0, P_CAN, 10'h000, P_ENC, 3'h0, P_CAPT, 3'h0,
                                      P_I2C, 3'h0, P_SPI, 1'b0, P_SER};
  localparam logic [31:0] EXP_CAP3 = {12'h000, P_TRIP, 6'h00, P_PWM};

  // ==========================================================
  // signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] addr_i = 12'h000;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic prot_wr_en_i = 1'b0;
  logic [15:0] rdata_o;
  logic wr_done_o;
  logic wr_blocked_o;
  logic rd_seen;
  logic wr_seen;
  int compares = 0;
  int miscompares = 0;
  logic [15:0] rd_q[$];
  logic [11:0] rd_a[$];
  logic [1:0] wr_q[$];

  always #12.5 clk_i = ~clk_i;

  dcr_regs #(
    .PART_NUMBER(P_PART),
    .PART_CLASS(P_CLASS),
    .SILICON_REV(P_REV),
    .HAS_FLOAT_ACCEL(P_FA),
    .RAM_BLOCKS(P_RAM),
    .HAS_CAN(P_CAN),
    .HAS_ENCODER(P_ENC),
    .HAS_CAPTURE(P_CAPT),
    .HAS_I2C(P_I2C),
    .HAS_SPI(P_SPI),
    .SERIAL_PORTS(P_SER),
    .TRIP_FILTERS(P_TRIP),
    .PWM_CHANNELS(P_PWM)
  ) DUT (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .prot_wr_en_i(prot_wr_en_i),
    .rdata_o(rdata_o),
    .wr_done_o(wr_done_o),
    .wr_blocked_o(wr_blocked_o)
  );

  // ==========================================================
  // expectations
  function automatic logic [15:0] exp_word(input logic [11:0] a);
    case (a)
      12'h882: exp_word = {P_CLASS, P_PART};
      12'h883: exp_word = P_REV;
      12'h886: exp_word = EXP_CAP1[15:0];
      12'h887: exp_word = EXP_CAP1[31:16];
      12'h888: exp_word = EXP_CAP2[15:0];
      12'h889: exp_word = EXP_CAP2[31:16];
      12'h88A: exp_word = EXP_CAP3[15:0];
      12'h88B: exp_word = EXP_CAP3[31:16];
      default: exp_word = 16'h0000;
    endcase
  endfunction : exp_word

  task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : check

  // ==========================================================
  // bus master: one strobe per call, so calls chain back to back
  task automatic rd(input logic [11:0] a);
    rd_i <= 1'b1;
    wr_i <= 1'b0;
    addr_i <= a;
    rd_q.push_back(exp_word(a));
    rd_a.push_back(a);
    @(posedge clk_i);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic p);
    rd_i <= 1'b0;
    wr_i <= 1'b1;
    addr_i <= a;
    // capability words carry reserved bits: write back what they read
    wdata_i <= (a >= 12'h886 && a <= 12'h88B) ? exp_word(a) : d;
    prot_wr_en_i <= p;
    wr_q.push_back((a >= 12'h886 && a <= 12'h88B) ? {p, ~p} : 2'b00);
    @(posedge clk_i);
  endtask : wr

  task automatic idle(input int n);
    rd_i <= 1'b0;
    wr_i <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask : idle

  // ==========================================================
  // monitor: strobes taken at an edge are answered in the following cycle only
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_seen <= 1'b0;
      wr_seen <= 1'b0;
    end else begin
      rd_seen <= rd_i;
      wr_seen <= wr_i;
    end
  end

  always @(negedge clk_i) begin : mon
    logic [1:0] w;
    if (rst_i) begin
      check("rdata in reset", 16'h0000, rdata_o);
      check("pulses in reset", 16'h0000, {14'h0000, wr_done_o, wr_blocked_o});
    end else begin
      if (rd_seen && rd_q.size() > 0) begin
        check($sformatf("rdata at %h", rd_a.pop_front()), rd_q.pop_front(), rdata_o);
      end else begin
        check("rdata idle", 16'h0000, rdata_o);
      end
      if (wr_seen && wr_q.size() > 0) begin
        w = wr_q.pop_front();
        check("write pulses", {14'h0000, w}, {14'h0000, wr_done_o, wr_blocked_o});
      end else begin
        check("idle pulses", 16'h0000, {14'h0000, wr_done_o, wr_blocked_o});
      end
    end
  end

  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // ==========================================================
  // main sequence
  initial begin : main
    logic [11:0] a;
    int k;
    void'($urandom(32'h3B05));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // every word back to back, first read right after release
    rd(12'h882);
    rd(12'h883);
    rd(12'h886);
    rd(12'h887);
    rd(12'h888);
    rd(12'h889);
    rd(12'h88A);
    rd(12'h88B);
    for (k = 0; k < 5; k++) begin
      rd(k < 2 ? 12'h880 + 12'(k) : 12'h882 + 12'(k));
    end
    idle(1);
    // protected writes refused, then taken, with the contents held either way
    for (k = 0; k < 6; k++) begin
      wr(12'h886 + 12'(k), 16'hFFFF, 1'b0);
    end
    for (k = 0; k < 6; k++) begin
      wr(12'h886 + 12'(k), 16'($urandom), 1'b1);
    end
    wr(12'h882, 16'hFFFF, 1'b1);
    wr(12'h883, 16'hFFFF, 1'b0);
    wr(12'h88C, 16'hFFFF, 1'b1);
    wr(12'h885, 16'hFFFF, 1'b1);
    for (k = 0; k < 6; k++) begin
      rd(12'h886 + 12'(k));
    end
    // random traffic around the bank
    repeat (80) begin
      a = 12'h87E + 12'($urandom_range(0, 15));
      if ($urandom_range(0, 1) == 1) begin
        rd(a);
      end else begin
        wr(a, 16'($urandom), 1'($urandom));
      end
    end
    // reset in mid-run, then the bank must read the same
    idle(2);
    rst_i <= 1'b1;
    idle(3);
    rst_i <= 1'b0;
    rd(12'h887);
    wr(12'h88A, 16'h0000, 1'b0);
    rd(12'h88A);
    idle(2);
    for (k = 0; k < 10 && (rd_q.size() > 0 || wr_q.size() > 0); k++) begin
      @(posedge clk_i);
    end
    if (rd_q.size() > 0 || wr_q.size() > 0) begin
      miscompares++;
      $display("wrong value pending notes expected %0d seen %0d", 0, rd_q.size() + wr_q.size());
    end
    complete_run();
  end
endmodule : tb_device_capability_id_regs
